// >>> bench/tormsk_top_monitor.sv
// concurrent checks on the or-mask block ports
// assumes bind onto tormsk_top, one clock domain
`timescale 1ns/10ps
`include "tormsk_consts.svh"

module tormsk_top_monitor (
  input wire logic        core_clk_i,
  input wire logic        srst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        or_trig_o,
  input wire logic        trig_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  chk_write_answer: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##2 s_axi_bvalid_o) else $error("write not answered");
  chk_bvalid_stands: assert property (
    s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  chk_write_refused: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  chk_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  chk_rvalid_stands: assert property (
    s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  chk_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during response");
  chk_unmapped_zero: assert property (
    s_axi_rvalid_o && s_axi_rresp_o == `TORMSK_RESP_SLVERR
    |-> s_axi_rdata_o == 32'h0)
    else $error("error read data not zero");
  chk_bresp_legal: assert property (s_axi_bvalid_o |->
    s_axi_bresp_o == `TORMSK_RESP_OKAY || s_axi_bresp_o == `TORMSK_RESP_SLVERR)
    else $error("bad write response code");
  chk_trig_pulse: assert property (trig_o |=> !trig_o)
    else $error("trigger pulse too long");
  chk_reset_quiet: assert property (
    $fell(srst_i) |-> !or_trig_o && !trig_o && !s_axi_bvalid_o && !s_axi_rvalid_o)
    else $error("outputs active after reset");
endmodule : tormsk_top_monitor

bind tormsk_top tormsk_top_monitor mon_u (
  .core_clk_i(core_clk_i), .srst_i(srst_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .or_trig_o(or_trig_o), .trig_o(trig_o));

// >>> bench/tormsk_top_tb.sv
// self-checking bench for the or-mask block over axi4-lite
// assumes ext1 absent, extra ttl and channel sources present
`timescale 1ns/10ps
`include "tormsk_consts.svh"

module tormsk_top_tb;
  localparam logic [17:0] A_SEL = 18'(`TORMSK_IDX_GEN_SEL * 4);
  localparam logic [17:0] A_AVL = 18'(`TORMSK_IDX_GEN_AVAIL * 4);
  localparam logic [17:0] A_CAH = 18'(`TORMSK_IDX_CH_AVAIL_HI * 4);
  localparam logic [17:0] A_CSL = 18'(`TORMSK_IDX_CH_SEL_LO * 4);
  localparam logic [17:0] A_CSH = 18'(`TORMSK_IDX_CH_SEL_HI * 4);
  localparam logic [17:0] A_CTL = 18'(`TORMSK_IDX_CONTROL * 4);
  localparam logic [17:0] A_STA = 18'(`TORMSK_IDX_STATUS * 4);
  localparam logic [1:0]  OK    = `TORMSK_RESP_OKAY;
  localparam logic [1:0]  ERR   = `TORMSK_RESP_SLVERR;

  logic                     core_clk_i = 1'b0;
  logic                     srst_i = 1'b1;
  logic [17:0]              awaddr = '0, araddr = '0;
  logic [31:0]              wdata = '0, rdata, rd_d;
  logic                     awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                     arvalid = 1'b0, rready = 1'b0;
  logic                     awready, wready, bvalid, arready, rvalid;
  logic                     or_trig, trig;
  logic [1:0]               bresp, rresp, rd_r;
  tormsk_pkg::tormsk_src_t  src = '0;
  tormsk_pkg::tormsk_chan_t chan = '0;
  logic [31:0]              sb [4] = '{32'h2, 32'h4, 32'h100, 32'h200};
  logic                     av [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int                       fails = 0, checks = 0, cyc = 0;

  always #5 core_clk_i = ~core_clk_i;

  tormsk_top #(.HAS_EXT1(1'b0), .HAS_XTTL(1'b1), .HAS_CHAN(1'b1)) dut_u (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .src_cond_i(src), .chan_trig_i(chan),
    .or_trig_o(or_trig), .trig_o(trig));

  task automatic final_report;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic wrc(input logic [17:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    do @(posedge core_clk_i); while (bvalid !== 1'b1);
    cmp({30'h0, bresp}, {30'h0, e});
  endtask : wrc

  task automatic rd(input logic [17:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk_i); while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
  endtask : rd

  task automatic rdc(input logic [17:0] a, input logic [31:0] e);
    rd(a);
    cmp(rd_d, e);
  endtask : rdc

  task automatic orchk(input logic e);
    repeat (6) @(posedge core_clk_i);
    cmp({31'h0, or_trig}, {31'h0, e});
  endtask : orchk

  // run with software source, measure delay, then no second pulse
  task automatic dly(input int n);
    int k;
    wrc(A_CTL, {8'h00, 16'(n), 7'h00, 1'b1}, OK);
    for (k = 0; k < 50 && or_trig !== 1'b1; k++) @(posedge core_clk_i);
    for (k = 0; k < 50 && trig !== 1'b1; k++) @(posedge core_clk_i);
    cmp(k, n + 1);
    k = 0;
    repeat (20) begin
      @(posedge core_clk_i);
      if (trig === 1'b1) k++;
    end
    cmp(k, 0);
    rdc(A_STA, 32'h7);
  endtask : dly

  initial begin
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    rdc(A_SEL, 32'h1);
    rdc(A_AVL, 32'h303);
    rdc(A_CSL, 32'h0);
    rdc(A_CAH, 32'hFFFF_FFFF);
    wrc(A_AVL, 32'h0, ERR);
    rdc(A_AVL, 32'h303);
    rd(18'h00000);
    cmp({30'h0, rd_r}, {30'h0, ERR});
    wrc(A_CSH, 32'h8000_0001, OK);
    rdc(A_CSH, 32'h8000_0001);
    dly(5);
    wrc(A_CTL, 32'h0, OK);
    dly(0);
    wrc(A_CTL, 32'h0, OK);
    wrc(A_SEL, 32'h3, OK);
    wrc(A_CTL, 32'h1, OK);
    orchk(1'b1);
    wrc(A_SEL, `TORMSK_NO_SOURCE, OK);
    wrc(A_CSH, 32'h0, OK);
    src <= '1;
    orchk(1'b0);
    for (int j = 0; j < 4; j++) begin
      wrc(A_SEL, sb[j], OK);
      src <= 4'(~(4'h1 << j));
      orchk(1'b0);
      src <= 4'(4'h1 << j);
      orchk(av[j]);
    end
    wrc(A_SEL, 32'h302, OK);
    rdc(A_SEL, 32'h302);
    src <= 4'h8;
    orchk(1'b1);
    wrc(A_SEL, 32'h0, OK);
    src <= '0;
    wrc(A_CSH, 32'h8000_0000, OK);
    chan <= {32'h7FFF_FFFF, 32'hFFFF_FFFF};
    orchk(1'b0);
    chan <= {32'h8000_0000, 32'h0};
    orchk(1'b1);
    wrc(A_CSH, 32'h0, OK);
    wrc(A_CSL, 32'h1, OK);
    chan <= {32'h0, 32'h1};
    orchk(1'b1);
    final_report;
  end
endmodule : tormsk_top_tb

// >>> hw/tormsk_delay.sv
// programmable delay counter between combined trigger and final event
// assumes all inputs are in the core_clk_i domain
`timescale 1ns/10ps
`include "tormsk_consts.svh"

module tormsk_delay (
  input  wire logic                         core_clk_i,
  input  wire logic                         srst_i,
  input  wire logic                         arm_i,
  input  wire logic                         hit_i,
  input  wire logic [`TORMSK_CTRL_DLY_W-1:0] delay_i,
  output tormsk_pkg::tormsk_state_t         state_o,
  output logic                              fire_o
);

  tormsk_pkg::tormsk_state_t     state_q;
  logic [`TORMSK_CTRL_DLY_W-1:0] cnt_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !arm_i) begin
      state_q <= tormsk_pkg::TORMSK_IDLE;
    end else begin
      unique case (state_q)
        tormsk_pkg::TORMSK_IDLE: begin
          state_q <= tormsk_pkg::TORMSK_ARMED;
        end
        tormsk_pkg::TORMSK_ARMED: begin
          if (hit_i) begin
            state_q <= (delay_i == '0) ? tormsk_pkg::TORMSK_FIRED
                                       : tormsk_pkg::TORMSK_DELAY;
          end
        end
        tormsk_pkg::TORMSK_DELAY: begin
          if (cnt_q == delay_i) begin
            state_q <= tormsk_pkg::TORMSK_FIRED;
          end
        end
        tormsk_pkg::TORMSK_FIRED: begin
          state_q <= tormsk_pkg::TORMSK_FIRED;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || state_q != tormsk_pkg::TORMSK_DELAY) begin
      cnt_q <= `TORMSK_CTRL_DLY_W'(1);
    end else begin
      cnt_q <= cnt_q + `TORMSK_CTRL_DLY_W'(1);
    end
  end

  // one-cycle event on entry to fired
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !arm_i) begin
      fire_o <= 1'b0;
    end else begin
      fire_o <= (state_q == tormsk_pkg::TORMSK_ARMED && hit_i &&
                 delay_i == '0) ||
                (state_q == tormsk_pkg::TORMSK_DELAY && cnt_q == delay_i);
    end
  end

  assign state_o = state_q;

endmodule : tormsk_delay

// >>> hw/tormsk_top.sv
// trigger or-mask selection with axi4-lite register slave
// assumes pin trigger inputs are asynchronous and channel triggers are
// already in the core_clk_i domain
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "tormsk_consts.svh"

module tormsk_top #(
  parameter bit HAS_EXT1 = 1'b0,
  parameter bit HAS_XTTL = 1'b0,
  parameter bit HAS_CHAN = 1'b0
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      srst_i,
  input  wire logic [`TORMSK_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                      s_axi_awvalid_i,
  output logic                           s_axi_awready_o,
  input  wire logic [31:0]               s_axi_wdata_i,
  input  wire logic [3:0]                s_axi_wstrb_i,
  input  wire logic                      s_axi_wvalid_i,
  output logic                           s_axi_wready_o,
  output logic [1:0]                     s_axi_bresp_o,
  output logic                           s_axi_bvalid_o,
  input  wire logic                      s_axi_bready_i,
  input  wire logic [`TORMSK_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                      s_axi_arvalid_i,
  output logic                           s_axi_arready_o,
  output logic [31:0]                    s_axi_rdata_o,
  output logic [1:0]                     s_axi_rresp_o,
  output logic                           s_axi_rvalid_o,
  input  wire logic                      s_axi_rready_i,
  input  wire tormsk_pkg::tormsk_src_t   src_cond_i,
  input  wire tormsk_pkg::tormsk_chan_t  chan_trig_i,
  output logic                           or_trig_o,
  output logic                           trig_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic [`TORMSK_ADDR_W-1:0] byte_addr(
    input logic [15:0] idx
  );
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // ----------------------------------------------------------------
  // availability masks
  // ----------------------------------------------------------------
  logic [31:0] gen_avail;
  logic [31:0] ch_avail_lo;
  logic [31:0] ch_avail_hi;

  always_comb begin
    gen_avail                        = '0;
    gen_avail[`TORMSK_BIT_SOFTWARE]  = 1'b1;
    gen_avail[`TORMSK_BIT_EXT0]      = 1'b1;
    gen_avail[`TORMSK_BIT_EXT1]      = HAS_EXT1;
    gen_avail[`TORMSK_BIT_XTTL0]     = HAS_XTTL;
    gen_avail[`TORMSK_BIT_XTTL1]     = HAS_XTTL;
  end

  assign ch_avail_lo = HAS_CHAN ? 32'hFFFF_FFFF : 32'h0000_0000;
  assign ch_avail_hi = HAS_CHAN ? 32'hFFFF_FFFF : 32'h0000_0000;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic                      aw_held_q;
  logic [`TORMSK_ADDR_W-1:0] aw_addr_q;
  logic                      w_held_q;
  logic [31:0]               w_data_q;
  logic [3:0]                w_strb_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      wr_go;

  assign s_axi_awready_o = !aw_held_q && !bvalid_q;
  assign s_axi_wready_o  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign wr_go           = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_i;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] gen_sel_q;
  logic [31:0] ch_sel_lo_q;
  logic [31:0] ch_sel_hi_q;
  logic [31:0] ctrl_q;
  logic        wr_hit;
  logic        sw_force;

  always_comb begin
    unique case (aw_addr_q)
      byte_addr(`TORMSK_IDX_GEN_SEL),
      byte_addr(`TORMSK_IDX_CH_SEL_LO),
      byte_addr(`TORMSK_IDX_CH_SEL_HI),
      byte_addr(`TORMSK_IDX_CONTROL):   wr_hit = 1'b1;
      default:                          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `TORMSK_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `TORMSK_RESP_OKAY : `TORMSK_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      gen_sel_q <= `TORMSK_GEN_SEL_RST;
    end else if (wr_go && aw_addr_q == byte_addr(`TORMSK_IDX_GEN_SEL)) begin
      gen_sel_q <= merge(gen_sel_q, w_data_q, w_strb_q);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ch_sel_lo_q <= `TORMSK_CH_SEL_RST;
      ch_sel_hi_q <= `TORMSK_CH_SEL_RST;
    end else if (wr_go) begin
      if (aw_addr_q == byte_addr(`TORMSK_IDX_CH_SEL_LO)) begin
        ch_sel_lo_q <= merge(ch_sel_lo_q, w_data_q, w_strb_q);
      end
      if (aw_addr_q == byte_addr(`TORMSK_IDX_CH_SEL_HI)) begin
        ch_sel_hi_q <= merge(ch_sel_hi_q, w_data_q, w_strb_q);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl_q <= `TORMSK_CTRL_RST;
    end else if (wr_go && aw_addr_q == byte_addr(`TORMSK_IDX_CONTROL)) begin
      ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tormsk_pkg::tormsk_src_t src_meta_q;
  tormsk_pkg::tormsk_src_t src_sync_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      src_meta_q <= '0;
      src_sync_q <= '0;
    end else begin
      src_meta_q <= src_cond_i;
      src_sync_q <= src_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // or-mask combination
  // ----------------------------------------------------------------
  logic        run;
  logic [31:0] gen_hits;
  logic [31:0] gen_eff;
  logic [63:0] ch_eff;
  logic        or_d;
  logic        or_q;

  assign run = ctrl_q[`TORMSK_CTRL_RUN];

  always_comb begin
    gen_hits                        = '0;
    gen_hits[`TORMSK_BIT_SOFTWARE]  = run;
    gen_hits[`TORMSK_BIT_EXT0]      = src_sync_q.ext0;
    gen_hits[`TORMSK_BIT_EXT1]      = src_sync_q.ext1;
    gen_hits[`TORMSK_BIT_XTTL0]     = src_sync_q.xttl0;
    gen_hits[`TORMSK_BIT_XTTL1]     = src_sync_q.xttl1;
  end

  // absent sources gated off by availability
  assign gen_eff = gen_sel_q & gen_avail & gen_hits;
  assign ch_eff  = {ch_sel_hi_q & ch_avail_hi,
                    ch_sel_lo_q & ch_avail_lo} & chan_trig_i;

  // selected software bit fires on run, ORed with the other selected sources
  assign sw_force = gen_eff[`TORMSK_BIT_SOFTWARE];
  assign or_d     = run && (sw_force || (|gen_eff) || (|ch_eff));

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      or_q <= 1'b0;
    end else begin
      or_q <= or_d;
    end
  end

  assign or_trig_o = or_q;

  // ----------------------------------------------------------------
  // trigger delay
  // ----------------------------------------------------------------
  tormsk_pkg::tormsk_state_t dly_state;

  tormsk_delay u_delay (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .arm_i      (run),
    .hit_i      (or_q),
    .delay_i    (ctrl_q[`TORMSK_CTRL_DLY_LSB +: `TORMSK_CTRL_DLY_W]),
    .state_o    (dly_state),
    .fire_o     (trig_o)
  );

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr_i)
      byte_addr(`TORMSK_IDX_GEN_SEL):     rd_mux = gen_sel_q;
      byte_addr(`TORMSK_IDX_GEN_AVAIL):   rd_mux = gen_avail;
      byte_addr(`TORMSK_IDX_CH_AVAIL_LO): rd_mux = ch_avail_lo;
      byte_addr(`TORMSK_IDX_CH_AVAIL_HI): rd_mux = ch_avail_hi;
      byte_addr(`TORMSK_IDX_CH_SEL_LO):   rd_mux = ch_sel_lo_q;
      byte_addr(`TORMSK_IDX_CH_SEL_HI):   rd_mux = ch_sel_hi_q;
      byte_addr(`TORMSK_IDX_CONTROL):     rd_mux = ctrl_q;
      byte_addr(`TORMSK_IDX_STATUS):      rd_mux = {29'h0, or_q,
                                                    dly_state};
      default: begin
        rd_mux = `TORMSK_NO_SOURCE;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `TORMSK_RESP_OKAY;
    end else if (s_axi_arvalid_i && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_mux;
      rresp_q  <= rd_hit ? `TORMSK_RESP_OKAY : `TORMSK_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : tormsk_top

// >>> shared/tormsk_consts.svh
// register offsets, field positions, reset values and response codes
// assumes inclusion by bare name from package and design files
`ifndef TORMSK_CONSTS_SVH
`define TORMSK_CONSTS_SVH

// ----------------------------------------------------------------
// register indices and byte address width
// ----------------------------------------------------------------
`define TORMSK_IDX_GEN_SEL     16'd40410
`define TORMSK_IDX_GEN_AVAIL   16'd40400
`define TORMSK_IDX_CH_AVAIL_LO 16'd40450
`define TORMSK_IDX_CH_AVAIL_HI 16'd40451
`define TORMSK_IDX_CH_SEL_LO   16'd40460
`define TORMSK_IDX_CH_SEL_HI   16'd40461
`define TORMSK_IDX_CONTROL     16'd40470
`define TORMSK_IDX_STATUS      16'd40471
`define TORMSK_ADDR_W          18

// ----------------------------------------------------------------
// general mask bit positions
// ----------------------------------------------------------------
`define TORMSK_BIT_SOFTWARE    0
`define TORMSK_BIT_EXT0        1
`define TORMSK_BIT_EXT1        2
`define TORMSK_BIT_XTTL0       8
`define TORMSK_BIT_XTTL1       9

// ----------------------------------------------------------------
// reset and constant values
// ----------------------------------------------------------------
`define TORMSK_NO_SOURCE       32'h0000_0000
`define TORMSK_GEN_SEL_RST     32'h0000_0001
`define TORMSK_CH_SEL_RST      32'h0000_0000
`define TORMSK_CTRL_RST        32'h0000_0000
`define TORMSK_DELAY_RST       32'h0000_0000

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TORMSK_CTRL_RUN        0
`define TORMSK_CTRL_DLY_LSB    8
`define TORMSK_CTRL_DLY_W      16

// ----------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------
`define TORMSK_RESP_OKAY       2'h0
`define TORMSK_RESP_SLVERR     2'h2

`endif

// >>> shared/tormsk_pkg.sv
// types shared by the trigger or-mask block
// assumes tormsk_consts.svh on the include path
`include "tormsk_consts.svh"

package tormsk_pkg;

  // ----------------------------------------------------------------
  // trigger source groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic xttl1;
    logic xttl0;
    logic ext1;
    logic ext0;
  } tormsk_src_t;

  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
  } tormsk_chan_t;

  typedef struct packed {
    logic       has_ext1;
    logic       has_xttl;
    logic       has_chan;
  } tormsk_opts_t;

  typedef enum logic [1:0] {
    TORMSK_IDLE,
    TORMSK_ARMED,
    TORMSK_DELAY,
    TORMSK_FIRED
  } tormsk_state_t;

endpackage : tormsk_pkg
